// ---- rtl/idcfg_regs.v ----
// The APB register port is this design's own decision.
`timescale 1ns/100ps
// Function
// - Upper byte of identity word shows the 8-bit ROM checksum, read-only
// - Lower byte of identity word shows identifier bits 23:16, read-only
// - Identifier valid only with at least two bits set
// - Word below identity word returns identifier bits 15:0, read-only
// - Reserved config bits store and return written value, reset zero
// - Hard-reset bit pulls shutdown pin low; clearing it releases the pull
// - Alive-counter bit appends alive-counter byte to every packet
// - ALU test bit feeds test data into ALU instead of converter
// - Watchdog-disable stops watchdog, leaves timeout flag untouched
// - Double-buffer bit moves results at next acquisition start
// - Check-disable bit turns off packet checking; resets to zero
// - Unlock bit resets to one; only enumeration broadcast clears it
// - Writing one to bit 0 pulses soft reset; reads as zero
`include "idcfg_regs.vh"

module idcfg_regs #(
  parameter ID_W = 24
) (
  input wire sys_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [7:0] rom_checksum,
  input wire [ID_W-1:0] factory_identifier,
  input wire enumeration_broadcast,
  output wire identifier_valid,
  output wire shutdown_pin_n_o,
  output wire shutdown_pin_n_oe,
  output wire alive_counter_en,
  output wire alu_test_en,
  output wire acq_watchdog_dis,
  output wire double_buffer_en,
  output wire packet_check_dis,
  output wire address_lock_release,
  output wire soft_reset_trigger
);

////////////////////////////////////////////////////////////////////////////////
// Bus decode
localparam RSV_W = `IDCFG_RSV_HI - `IDCFG_RSV_LO + 1;

wire acc;
wire wr;
wire rd_setup;
wire hit_low;
wire hit_chk;
wire hit_cfg;
wire hit_any;
wire wr_cfg;

assign acc = psel & penable;
assign wr = acc & pwrite;
assign rd_setup = psel & ~penable & ~pwrite;
assign hit_low = (paddr == `IDCFG_ADDR_ID_LOW);
assign hit_chk = (paddr == `IDCFG_ADDR_ID_CHK);
assign hit_cfg = (paddr == `IDCFG_ADDR_CONFIG);
assign hit_any = hit_low | hit_chk | hit_cfg;
assign wr_cfg = wr & hit_cfg;

// Zero wait states; unmapped addresses flag an error
assign pready = 1'b1;
assign pslverr = acc & ~hit_any;

////////////////////////////////////////////////////////////////////////////////
// Population count as an adder chain, one stage per identifier bit
wire [4:0] ones_acc [0:ID_W];
genvar g;

assign ones_acc[0] = 5'h00;

generate
  for (g = 0; g < ID_W; g = g + 1) begin : g_pop
    assign ones_acc[g + 1] = ones_acc[g] + {4'h0, factory_identifier[g]};
  end
endgenerate

assign identifier_valid = (ones_acc[ID_W] >= `IDCFG_ID_MIN_ONES);

////////////////////////////////////////////////////////////////////////////////
// Identity words come straight from fuses, so writes cannot touch them
wire [15:0] id_low_word;
wire [15:0] id_chk_word;

assign id_low_word = factory_identifier[`IDCFG_ID_LOW_HI:`IDCFG_ID_LOW_LO];
assign id_chk_word[15:8] = rom_checksum;
assign id_chk_word[7:0] = factory_identifier[`IDCFG_ID_MSB_HI:`IDCFG_ID_MSB_LO];

////////////////////////////////////////////////////////////////////////////////
// Hard-reset request
reg hard_rst_ff;
reg nxt_hard_rst;

always @* begin
  nxt_hard_rst = hard_rst_ff;
  if (wr_cfg) begin
    nxt_hard_rst = pwdata[`IDCFG_BIT_HARD_RST];
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    hard_rst_ff <= `IDCFG_RST_OFF;
  end else begin
    hard_rst_ff <= nxt_hard_rst;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Alive-counter enable
reg alive_ff;
reg nxt_alive;

always @* begin
  nxt_alive = alive_ff;
  if (wr_cfg) begin
    nxt_alive = pwdata[`IDCFG_BIT_ALIVE];
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    alive_ff <= `IDCFG_RST_OFF;
  end else begin
    alive_ff <= nxt_alive;
  end
end

////////////////////////////////////////////////////////////////////////////////
// ALU test enable
reg alu_test_ff;
reg nxt_alu_test;

always @* begin
  nxt_alu_test = alu_test_ff;
  if (wr_cfg) begin
    nxt_alu_test = pwdata[`IDCFG_BIT_ALU_TEST];
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    alu_test_ff <= `IDCFG_RST_OFF;
  end else begin
    alu_test_ff <= nxt_alu_test;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Watchdog disable; the timeout flag is held elsewhere and never cleared here
reg wdog_dis_ff;
reg nxt_wdog_dis;

always @* begin
  nxt_wdog_dis = wdog_dis_ff;
  if (wr_cfg) begin
    nxt_wdog_dis = pwdata[`IDCFG_BIT_WDOG_DIS];
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    wdog_dis_ff <= `IDCFG_RST_OFF;
  end else begin
    wdog_dis_ff <= nxt_wdog_dis;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Double-buffer enable
reg dbl_buf_ff;
reg nxt_dbl_buf;

always @* begin
  nxt_dbl_buf = dbl_buf_ff;
  if (wr_cfg) begin
    nxt_dbl_buf = pwdata[`IDCFG_BIT_DBL_BUF];
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    dbl_buf_ff <= `IDCFG_RST_OFF;
  end else begin
    dbl_buf_ff <= nxt_dbl_buf;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Packet-check disable; checking stays on after reset
reg pec_dis_ff;
reg nxt_pec_dis;

always @* begin
  nxt_pec_dis = pec_dis_ff;
  if (wr_cfg) begin
    nxt_pec_dis = pwdata[`IDCFG_BIT_PEC_DIS];
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    pec_dis_ff <= `IDCFG_RST_OFF;
  end else begin
    pec_dis_ff <= nxt_pec_dis;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Address unlock; host writes leave it alone, so a stray write cannot unlock it again
reg unlock_ff;
reg nxt_unlock;

always @* begin
  nxt_unlock = unlock_ff;
  if (enumeration_broadcast) begin
    nxt_unlock = 1'b0;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    unlock_ff <= `IDCFG_RST_UNLOCK;
  end else begin
    unlock_ff <= nxt_unlock;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Reserved bits are plain storage
wire [RSV_W-1:0] rsv_q;
genvar r;

generate
  for (r = 0; r < RSV_W; r = r + 1) begin : g_rsv
    reg bit_ff;
    always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        bit_ff <= `IDCFG_RST_OFF;
      end else if (wr_cfg) begin
        bit_ff <= pwdata[`IDCFG_RSV_LO + r];
      end
    end
    assign rsv_q[r] = bit_ff;
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Soft reset; a one-cycle pulse, never stored
reg soft_reset_trigger_ff;
reg nxt_soft_reset_trigger;

always @* begin
  nxt_soft_reset_trigger = 1'b0;
  if (wr_cfg) begin
    nxt_soft_reset_trigger = pwdata[`IDCFG_BIT_SOFT_RST];
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    soft_reset_trigger_ff <= 1'b0;
  end else begin
    soft_reset_trigger_ff <= nxt_soft_reset_trigger;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration word as seen by reads
wire [15:0] cfg_word;

assign cfg_word[`IDCFG_RSV_HI:`IDCFG_RSV_LO] = rsv_q;
assign cfg_word[`IDCFG_BIT_HARD_RST] = hard_rst_ff;
assign cfg_word[`IDCFG_BIT_ALIVE] = alive_ff;
assign cfg_word[`IDCFG_BIT_ALU_TEST] = alu_test_ff;
assign cfg_word[`IDCFG_BIT_WDOG_DIS] = wdog_dis_ff;
assign cfg_word[`IDCFG_BIT_DBL_BUF] = dbl_buf_ff;
assign cfg_word[`IDCFG_BIT_PEC_DIS] = pec_dis_ff;
assign cfg_word[`IDCFG_BIT_UNLOCK] = unlock_ff;
assign cfg_word[`IDCFG_BIT_SOFT_RST] = 1'b0;

////////////////////////////////////////////////////////////////////////////////
// Read mux; upper half of the bus word always reads zero
reg [31:0] nxt_rdata;

always @* begin
  nxt_rdata = 32'h00000000;
  if (hit_low) begin
    nxt_rdata[15:0] = id_low_word;
  end else if (hit_chk) begin
    nxt_rdata[15:0] = id_chk_word;
  end else if (hit_cfg) begin
    nxt_rdata[15:0] = cfg_word;
  end
end

// Captured in the setup cycle so the access phase needs no wait state
always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    prdata <= 32'h00000000;
  end else if (rd_setup) begin
    prdata <= nxt_rdata;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Open-drain pull-down; clearing the bit or a reset releases it
assign shutdown_pin_n_o = 1'b0;
assign shutdown_pin_n_oe = hard_rst_ff;
assign alive_counter_en = alive_ff;
assign alu_test_en = alu_test_ff;
assign acq_watchdog_dis = wdog_dis_ff;
assign double_buffer_en = dbl_buf_ff;
assign packet_check_dis = pec_dis_ff;
assign address_lock_release = unlock_ff;
assign soft_reset_trigger = soft_reset_trigger_ff;

endmodule

// ---- rtl/idcfg_regs.vh ----
`ifndef IDCFG_REGS_VH
`define IDCFG_REGS_VH
// Register indices as printed; byte address is four times the index
`define IDCFG_IDX_ID_LOW 8'h0D
`define IDCFG_IDX_ID_CHK 8'h0E
`define IDCFG_IDX_CONFIG 8'h10
`define IDCFG_ADDR_ID_LOW 12'h034
`define IDCFG_ADDR_ID_CHK 12'h038
`define IDCFG_ADDR_CONFIG 12'h040
// Configuration word fields
`define IDCFG_BIT_HARD_RST 7
`define IDCFG_BIT_ALIVE 6
`define IDCFG_BIT_ALU_TEST 5
`define IDCFG_BIT_WDOG_DIS 4
`define IDCFG_BIT_DBL_BUF 3
`define IDCFG_BIT_PEC_DIS 2
`define IDCFG_BIT_UNLOCK 1
`define IDCFG_BIT_SOFT_RST 0
`define IDCFG_RSV_HI 15
`define IDCFG_RSV_LO 8
`define IDCFG_CFG_RESET 16'h0002
`define IDCFG_CFG_WMASK 16'hFFFE
`define IDCFG_ID_MIN_ONES 5'h02
// Identity field positions
`define IDCFG_ID_LOW_HI 15
`define IDCFG_ID_LOW_LO 0
`define IDCFG_ID_MSB_HI 23
`define IDCFG_ID_MSB_LO 16
// Per-field reset values
`define IDCFG_RST_OFF 1'b0
`define IDCFG_RST_UNLOCK 1'b1
`endif

// ---- verif/idcfg_checker.sv ----
`timescale 1ns/100ps
module idcfg_checker(input wire sys_clk,rstn,psel,penable,pwrite,pslverr,enumeration_broadcast,
  input wire shutdown_pin_n_oe,address_lock_release,soft_reset_trigger,packet_check_dis,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,prdata);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire w=psel&penable&pwrite&(paddr==12'h040);
  wire lk=address_lock_release;
  property p_sr; soft_reset_trigger|->$past(w&pwdata[0]); endproperty
  a_sr: assert property(p_sr) else $error("stray soft reset");
  property p_sr1; w&pwdata[0]|=>soft_reset_trigger; endproperty
  a_sr1: assert property(p_sr1) else $error("no soft reset");
  property p_hr; w|=>shutdown_pin_n_oe==$past(pwdata[7]); endproperty
  a_hr: assert property(p_hr) else $error("bad pull");
  property p_pc; w|=>packet_check_dis==$past(pwdata[2]); endproperty
  a_pc: assert property(p_pc) else $error("bad check bit");
  property p_bc; enumeration_broadcast|=>!lk; endproperty
  a_bc: assert property(p_bc) else $error("lock kept");
  property p_lk; !lk|=>!lk; endproperty
  a_lk: assert property(p_lk) else $error("lock reopened");
  property p_rd; psel&penable&!pwrite&paddr==12'h040|->prdata[31:16]==0&&!prdata[0]; endproperty
  a_rd: assert property(p_rd) else $error("bad read");
  property p_er; psel&penable&paddr!=12'h034&paddr!=12'h038&paddr!=12'h040|->pslverr; endproperty
  a_er: assert property(p_er) else $error("no error");
  c_hr: cover property(w&pwdata[7]);
  c_bc: cover property(enumeration_broadcast);
  c_er: cover property(pslverr);
endmodule
bind idcfg_regs idcfg_checker idcfg_checker_i(.*);

// ---- verif/idcfg_host_model.sv ----
`timescale 1ns/100ps
module idcfg_host_model #(parameter CHK=8'h5A)(input wire sys_clk,go,
  input wire [23:0] id,
  output reg enumeration_broadcast=1'b0,
  output wire [7:0] rom_checksum,
  output wire [23:0] factory_identifier);
  // Checksum value is arbitrary
  assign rom_checksum=CHK;
  assign factory_identifier=id;
  always @(posedge sys_clk) enumeration_broadcast<=go;
endmodule

// ---- verif/test_idcfg_regs.sv ----
`timescale 1ns/100ps
module test_idcfg_regs;
  reg sys_clk=0,rstn=0,psel=0,penable=0,pwrite=0,go=0,re;
  reg [11:0] paddr=0;
  reg [31:0] pwdata=0,rv;
  reg [23:0] id=24'h000001;
  wire pready,pslverr,identifier_valid,shutdown_pin_n_o,shutdown_pin_n_oe,alive_counter_en,
    alu_test_en,acq_watchdog_dis,double_buffer_en,packet_check_dis,address_lock_release,
    soft_reset_trigger,enumeration_broadcast;
  wire [31:0] prdata;
  wire [7:0] rom_checksum;
  wire [23:0] factory_identifier;
  integer err_count=0,cmp_count=0;
  idcfg_host_model idcfg_host_model_i(.*);
  idcfg_regs idcfg_regs_i(.*);
  initial forever #10 sys_clk=~sys_clk;
  task chk(input [31:0] a,input [31:0] e);
    cmp_count=cmp_count+1;
    if (a!==e) begin
      err_count=err_count+1;
      $display("[FAIL] %0t got %h exp %h",$time,a,e);
    end
  endtask
  // Request held until pready seen high
  task xfer(input w,input [11:0] a,input [31:0] d);
    @(posedge sys_clk);
    psel<=1; pwrite<=w; paddr<=a; pwdata<=d;
    @(posedge sys_clk);
    penable<=1;
    @(posedge sys_clk);
    while (pready!==1'b1) @(posedge sys_clk);
    rv=prdata;
    re=pslverr;
    psel<=0; penable<=0;
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d",cmp_count,err_count);
    if (err_count==0 && cmp_count>0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_count=err_count+1;
    wrap_up;
  end
  initial begin
    repeat(3) @(posedge sys_clk);
    rstn<=1;
    xfer(0,12'h040,0); chk(rv,32'h2);
    xfer(0,12'h038,0); chk(rv,32'h5A00);
    chk(identifier_valid,0);
    id<=24'h030000;
    xfer(1,12'h038,32'hFFFFFFFF); xfer(0,12'h038,0); chk(rv,32'h5A03);
    xfer(0,12'h034,0); chk(rv,0);
    chk(identifier_valid,1);
    $display("identity test done");
    xfer(1,12'h040,32'hFFFF); #1 chk(soft_reset_trigger,1);
    xfer(0,12'h040,0); chk(rv,32'hFFFE);
    chk({shutdown_pin_n_o,shutdown_pin_n_oe,alive_counter_en,alu_test_en,acq_watchdog_dis,
      double_buffer_en,packet_check_dis,address_lock_release},8'h7F);
    xfer(1,12'h040,32'h2); xfer(0,12'h040,0); chk(rv,32'h2);
    chk({shutdown_pin_n_oe,packet_check_dis,soft_reset_trigger},0);
    xfer(1,12'h040,0); xfer(0,12'h040,0); chk(rv,32'h2);
    $display("config test done");
    go<=1;
    @(posedge sys_clk) go<=0;
    repeat(2) @(posedge sys_clk);
    xfer(1,12'h040,32'h2); xfer(0,12'h040,0); chk(rv,0);
    xfer(0,12'h044,0); chk(rv,0); chk(re,1);
    $display("lock test done");
    wrap_up;
  end
endmodule
